// >>> hw/phy_mgmt_status_ext_regs.sv
`include "phy_mgmt_params.svh"

module phy_mgmt_status_ext_regs
    import phy_mgmt_pkg::*;
#(
    parameter int STABLE_CYCLES = `STABLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        soft_rst,
    input  wire logic [4:0]  phy_addr,
    input  wire logic [1:0]  strap_mode,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  phy_events_s      ev,
    output phy_ctrl_s        ctrl
);
    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [15:0] int_enable;
        logic [15:0] int_status;
        logic [15:0] speed_cfg;
        logic [15:0] rx_errors;
        logic [15:0] ext_index;
        logic [15:0] slow_power;
        logic [15:0] combo;
        logic        act_dg_en;
        logic [2:0]  act_limit;
        logic        strap_done;
        logic        prev_link;
        logic [1:0]  prev_speed;
        logic        prev_duplex;
        logic        prev_pol;
        phy_ctrl_s   ctrl;
    } bank_s;

    bank_s s_ff;
    bank_s nxt_s;

    mgmt_req_s   req;
    logic [15:0] rdata;
    logic [15:0] ext_rdata;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic        dg_level;
    logic        dg_event;

    assign ctrl = s_ff.ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    mdio_serial_port u_port (
        .clk      (clk),
        .rst      (rst),
        .phy_addr (phy_addr),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .rdata    (rdata),
        .latch_en (s_ff.speed_cfg[`SPD_LATCH_BIT]),
        .req      (req),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe)
    );

    // Downgrade enable and limit use the settings copied at soft reset; bypass follows the live speed_cfg bit
    speed_downgrade_fsm #(
        .STABLE_CYCLES (STABLE_CYCLES)
    ) u_downgrade (
        .clk        (clk),
        .rst        (rst),
        .restart    (soft_rst),
        .enable     (s_ff.act_dg_en),
        .limit      (s_ff.act_limit),
        .bypass     (s_ff.speed_cfg[`SPD_BYPASS_BIT]),
        .link_up    (ev.link_up),
        .an_attempt (ev.an_attempt),
        .downgraded (dg_level),
        .dg_event   (dg_event)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb begin
        unique case (s_ff.ext_index)
            `EXT_SLOW_POWER: ext_rdata = s_ff.slow_power;
            `EXT_COMBO:      ext_rdata = s_ff.combo;
            default:         ext_rdata = 16'h0000;
        endcase
    end

    always_comb begin
        unique case (req.addr)
            `REG_INT_ENABLE: rdata = s_ff.int_enable;
            `REG_INT_STATUS: rdata = s_ff.int_status;
            `REG_SPEED_CFG:  rdata = s_ff.speed_cfg;
            `REG_RX_ERRORS:  rdata = s_ff.rx_errors;
            `REG_EXT_INDEX:  rdata = s_ff.ext_index;
            `REG_EXTENDED_WINDOW_DATA:   rdata = ext_rdata;
            default:         rdata = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Status events

    always_comb begin
        // Compares are quiet for one cycle after reset
        set_vec                 = 16'h0000;
        set_vec[`INT_AN_ERR]    = ev.an_err;
        set_vec[`INT_SPEED]     = s_ff.strap_done && ev.speed != s_ff.prev_speed;
        set_vec[`INT_DUPLEX]    = s_ff.strap_done && ev.duplex != s_ff.prev_duplex;
        set_vec[`INT_PAGE]      = ev.page_rx;
        set_vec[`INT_LINK_FAIL] = s_ff.prev_link && !ev.link_up;
        set_vec[`INT_LINK_UP]   = s_ff.strap_done && !s_ff.prev_link && ev.link_up;
        set_vec[`INT_WAKE]      = ev.wake;
        set_vec[`INT_DOWNGRADE] = dg_event;
        set_vec[`INT_POLARITY]  = s_ff.strap_done && ev.polarity != s_ff.prev_pol;
        set_vec[`INT_JABBER]    = ev.jabber;
        clr_vec = (req.rd && req.addr == `REG_INT_STATUS) ? 16'hffff : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_s = s_ff;

        nxt_s.prev_link   = ev.link_up;
        nxt_s.prev_speed  = ev.speed;
        nxt_s.prev_duplex = ev.duplex;
        nxt_s.prev_pol    = ev.polarity;

        // An event in the clearing cycle survives the read
        nxt_s.int_status = ((s_ff.int_status & ~clr_vec) | set_vec)
                           & `INT_VALID_MASK;

        // Counter holds at the top rather than wrapping
        if (ev.rx_er && s_ff.rx_errors != `RX_ERR_MAX) begin
            nxt_s.rx_errors = s_ff.rx_errors + 16'h0001;
        end

        if (req.wr) begin
            unique case (req.addr)
                `REG_INT_ENABLE: nxt_s.int_enable = req.wdata;
                `REG_SPEED_CFG: begin
                    nxt_s.speed_cfg = (s_ff.speed_cfg & ~`SPD_RW_MASK)
                                      | (req.wdata & `SPD_RW_MASK);
                end
                `REG_RX_ERRORS: nxt_s.rx_errors = {15'h0000, ev.rx_er};
                `REG_EXT_INDEX: nxt_s.ext_index = req.wdata;
                `REG_EXTENDED_WINDOW_DATA: begin
                    unique case (s_ff.ext_index)
                        `EXT_SLOW_POWER: nxt_s.slow_power = req.wdata;
                        `EXT_COMBO:      nxt_s.combo = req.wdata;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // Straps are caught on the first cycle after reset release
        if (!s_ff.strap_done) begin
            nxt_s.strap_done = 1'b1;
            nxt_s.combo[`CMB_RMII:`CMB_CLK_SEL] = strap_mode;
        end

        // Downgrade enable and limit only move on a soft reset
        if (soft_rst) begin
            nxt_s.act_dg_en = s_ff.speed_cfg[`SPD_DG_EN_BIT];
            nxt_s.act_limit = s_ff.speed_cfg[`SPD_ATT_HI:`SPD_ATT_LO];
        end

        ////////////////////////////////////////////////////////////////////
        // Outputs

        nxt_s.ctrl.irq = |(nxt_s.int_status & nxt_s.int_enable);
        nxt_s.ctrl.tx_dac_on = !(nxt_s.slow_power[`PWR_IDLE_BIT]
                                 && ev.speed == `SPEED_10M && !ev.tx_busy);
        nxt_s.ctrl.jumbo_accept    = nxt_s.combo[`CMB_JUMBO];
        nxt_s.ctrl.crs_dv_pin      = nxt_s.combo[`CMB_CRS_SEL] ? ev.rx_dv : ev.crs_dv_raw;
        nxt_s.ctrl.mac_mode        = nxt_s.combo[`CMB_RMII:`CMB_CLK_SEL];
        nxt_s.ctrl.clk_input       = nxt_s.combo[`CMB_CLK_SEL];
        nxt_s.ctrl.wol_enable      = nxt_s.combo[`CMB_WAKE];
        nxt_s.ctrl.remote_loopback = nxt_s.combo[`CMB_REM_LOOP];
        nxt_s.ctrl.speed_downgrade = dg_level;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff                <= '0;
            s_ff.speed_cfg      <= `SPD_RST;
            s_ff.slow_power     <= `PWR_RST;
            s_ff.act_dg_en      <= 1'(`SPD_RST >> `SPD_DG_EN_BIT);
            s_ff.act_limit      <= 3'(`SPD_RST >> `SPD_ATT_LO);
            s_ff.ctrl.tx_dac_on <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule : phy_mgmt_status_ext_regs

// >>> include/phy_mgmt_params.svh
`ifndef PHY_MGMT_PARAMS_SVH
`define PHY_MGMT_PARAMS_SVH

// Management register offsets
`define REG_INT_ENABLE   5'h12
`define REG_INT_STATUS   5'h13
`define REG_SPEED_CFG    5'h14
`define REG_RX_ERRORS    5'h15
`define REG_EXT_INDEX    5'h1e
`define REG_EXTENDED_WINDOW_DATA     5'h1f
`define EXT_SLOW_POWER   16'h200a
`define EXT_COMBO        16'h4000

// Interrupt status bits
`define INT_AN_ERR       15
`define INT_SPEED        14
`define INT_DUPLEX       13
`define INT_PAGE         12
`define INT_LINK_FAIL    11
`define INT_LINK_UP      10
`define INT_WAKE         6
`define INT_DOWNGRADE    5
`define INT_POLARITY     1
`define INT_JABBER       0
`define INT_VALID_MASK   16'hfc63

// Speed configuration fields
`define SPD_LATCH_BIT    11
`define SPD_DG_EN_BIT    5
`define SPD_ATT_HI       4
`define SPD_ATT_LO       2
`define SPD_BYPASS_BIT   1
`define SPD_RW_MASK      16'h0ffe
`define SPD_RST          16'h082c
`define ATTEMPT_EXTRA    4'h2

// Extended register fields
`define PWR_IDLE_BIT     10
`define PWR_RST          16'hca02
`define CMB_REM_LOOP     11
`define CMB_JUMBO        5
`define CMB_CRS_SEL      4
`define CMB_WAKE         2
`define CMB_RMII         1
`define CMB_CLK_SEL      0
`define RX_ERR_MAX       16'hffff
`define SPEED_10M        2'h0

// Serial management framing
`define MDIO_PRE_LEN     6'h20
`define MDIO_OP_READ     2'h2
`define MDIO_OP_WRITE    2'h1
`define MDIO_ADDR_LAST   5'h0b
`define MDIO_TA_FIRST    5'h0c
`define MDIO_BIT_BASE    5'h1c
`define MDIO_FRAME_LAST  5'h1d

// Timing
`define CLK_HZ           20000000
`define STABLE_TIME_MS   2500
`define STABLE_CYCLES    (`STABLE_TIME_MS * (`CLK_HZ / 1000))
`endif

// >>> include/phy_mgmt_pkg.sv
package phy_mgmt_pkg;
    typedef enum logic [1:0] {
        MD_IDLE  = 2'h0,
        MD_START = 2'h1,
        MD_FRAME = 2'h3
    } mdio_state_e;

    typedef enum logic [1:0] {
        DG_IDLE = 2'h0,
        DG_UP   = 2'h1,
        DG_DOWN = 2'h3
    } dg_state_e;

    typedef struct packed {
        logic       an_err;
        logic       page_rx;
        logic       wake;
        logic       jabber;
        logic       rx_er;
        logic       an_attempt;
        logic       link_up;
        logic       duplex;
        logic       polarity;
        logic [1:0] speed;
        logic       tx_busy;
        logic       crs_dv_raw;
        logic       rx_dv;
    } phy_events_s;

    typedef struct packed {
        logic       irq;
        logic       tx_dac_on;
        logic       jumbo_accept;
        logic       crs_dv_pin;
        logic [1:0] mac_mode;
        logic       clk_input;
        logic       wol_enable;
        logic       remote_loopback;
        logic       speed_downgrade;
    } phy_ctrl_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_s;
endpackage : phy_mgmt_pkg

// >>> hw/mdio_serial_port.sv
`include "phy_mgmt_params.svh"

module mdio_serial_port
    import phy_mgmt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  phy_addr,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    input  wire logic [15:0] rdata,
    input  wire logic        latch_en,
    output mgmt_req_s        req,
    output logic             mdio_out,
    output logic             mdio_oe
);
    typedef struct packed {
        mdio_state_e st;
        logic        mdc_prev;
        logic [5:0]  pre_cnt;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic        is_read;
        logic        hit;
        logic [15:0] rbuf;
        logic        out;
        logic        oe;
        mgmt_req_s   req;
    } port_s;

    port_s s_ff;
    port_s nxt_s;
    logic [4:0] bit_idx;
    logic [15:0] word;

    assign req      = s_ff.req;
    assign mdio_out = s_ff.out;
    assign mdio_oe  = s_ff.oe;
    assign bit_idx  = `MDIO_BIT_BASE - s_ff.cnt;
    // Unlatched reads follow the live register, so a bit may tear mid-frame
    assign word     = latch_en ? s_ff.rbuf : rdata;

    always_comb begin
        nxt_s          = s_ff;
        nxt_s.req.rd   = 1'b0;
        nxt_s.req.wr   = 1'b0;
        nxt_s.mdc_prev = mdc;
        if (mdc && !s_ff.mdc_prev) begin
            nxt_s.sh = {s_ff.sh[14:0], mdio_in};
            unique case (s_ff.st)
                MD_IDLE: begin
                    if (mdio_in) begin
                        if (s_ff.pre_cnt != `MDIO_PRE_LEN) nxt_s.pre_cnt = s_ff.pre_cnt + 6'h01;
                    end else begin
                        if (s_ff.pre_cnt == `MDIO_PRE_LEN) nxt_s.st = MD_START;
                        nxt_s.pre_cnt = 6'h00;
                    end
                end
                MD_START: begin
                    nxt_s.cnt = 5'h00;
                    nxt_s.st  = mdio_in ? MD_FRAME : MD_IDLE;
                end
                MD_FRAME: begin
                    nxt_s.cnt = s_ff.cnt + 5'h01;
                    if (s_ff.cnt == `MDIO_ADDR_LAST) begin
                        nxt_s.is_read  = nxt_s.sh[11:10] == `MDIO_OP_READ;
                        nxt_s.hit      = nxt_s.sh[9:5] == phy_addr &&
                                         (nxt_s.sh[11:10] == `MDIO_OP_READ ||
                                          nxt_s.sh[11:10] == `MDIO_OP_WRITE);
                        nxt_s.req.addr = nxt_s.sh[4:0];
                    end
                    if (s_ff.cnt == `MDIO_TA_FIRST && s_ff.hit && s_ff.is_read) begin
                        // Capture before the read side effects land next cycle
                        nxt_s.rbuf   = rdata;
                        nxt_s.req.rd = 1'b1;
                        nxt_s.oe     = 1'b1;
                        nxt_s.out    = 1'b0;
                    end else if (s_ff.oe && s_ff.cnt != `MDIO_FRAME_LAST) begin
                        nxt_s.out = word[bit_idx[3:0]];
                    end
                    if (s_ff.cnt == `MDIO_FRAME_LAST) begin
                        nxt_s.oe      = 1'b0;
                        nxt_s.out     = 1'b0;
                        nxt_s.st      = MD_IDLE;
                        nxt_s.pre_cnt = 6'h00;
                        if (s_ff.hit && !s_ff.is_read) begin
                            nxt_s.req.wr    = 1'b1;
                            nxt_s.req.wdata = nxt_s.sh;
                        end
                    end
                end
                default: nxt_s.st = MD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) s_ff <= '0;
        else     s_ff <= nxt_s;
    end
endmodule : mdio_serial_port

// >>> hw/speed_downgrade_fsm.sv
`include "phy_mgmt_params.svh"

module speed_downgrade_fsm
    import phy_mgmt_pkg::*;
#(
    parameter int STABLE_CYCLES = `STABLE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       restart,
    input  wire logic       enable,
    input  wire logic [2:0] limit,
    input  wire logic       bypass,
    input  wire logic       link_up,
    input  wire logic       an_attempt,
    output logic            downgraded,
    output logic            dg_event
);
    localparam logic [25:0] STABLE_LAST = 26'(STABLE_CYCLES - 1);

    typedef struct packed {
        dg_state_e   st;
        logic [3:0]  fails;
        logic [25:0] tmr;
        logic        down;
        logic        evt;
    } dg_s;

    dg_s s_ff;
    dg_s nxt_s;
    logic fail;
    logic stable;

    assign downgraded = s_ff.down;
    assign dg_event   = s_ff.evt;
    assign stable     = bypass || s_ff.tmr == STABLE_LAST;

    always_comb begin
        nxt_s     = s_ff;
        nxt_s.evt = 1'b0;
        fail      = 1'b0;
        unique case (s_ff.st)
            DG_IDLE: begin
                if (link_up) begin
                    nxt_s.st  = DG_UP;
                    nxt_s.tmr = 26'h0;
                end else if (an_attempt) begin
                    fail = 1'b1;
                end
            end
            DG_UP: begin
                if (!link_up) begin
                    nxt_s.st = DG_IDLE;
                    fail     = !stable;
                end else if (stable) begin
                    nxt_s.fails = 4'h0;
                end else begin
                    nxt_s.tmr = s_ff.tmr + 26'h1;
                end
            end
            DG_DOWN: ;
        endcase
        if (fail && enable) begin
            nxt_s.fails = s_ff.fails + 4'h1;
            if (nxt_s.fails >= {1'b0, limit} + `ATTEMPT_EXTRA) begin
                nxt_s.st   = DG_DOWN;
                nxt_s.down = 1'b1;
                nxt_s.evt  = 1'b1;
            end
        end
        if (restart) nxt_s = '0;
    end

    always_ff @(posedge clk) begin
        if (rst) s_ff <= '0;
        else     s_ff <= nxt_s;
    end
endmodule : speed_downgrade_fsm

// >>> test/mdio_host_model.sv
module mdio_host_model (
    input  wire logic clk,
    input  wire logic mdio,
    output logic      mdc,
    output logic      drv_oe,
    output logic      drv_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Extra low-phase clocks per bit
    int slow = 0;
    initial begin
        mdc = 1'b0;
        drv_oe = 1'b0;
        drv_bit = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regn,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta_low);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, op, phy, regn, 2'b10, wd};
        rd = 16'h0000;
        ta_low = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk) #1;
            mdc = 1'b0;
            // Released on reads from the turnaround
            drv_oe = (op == 2'b01) || (i > 17);
            drv_bit = bits[i];
            repeat (1 + slow) @(posedge clk);
            #1;
            if (i == 16) ta_low = !mdio;
            if (i < 16) rd[i] = mdio;
            mdc = 1'b1;
            repeat (2) @(posedge clk);
        end
        #1;
        mdc = 1'b0;
        drv_oe = 1'b0;
        repeat (3) @(posedge clk) #1;
    endtask : frame
endmodule : mdio_host_model

// >>> test/phy_mgmt_status_ext_regs_sva.sv
module phy_mgmt_sva
    import phy_mgmt_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        soft_rst,
    input wire logic [1:0]  strap_mode,
    input wire logic        mdc,
    input wire logic        mdio_out,
    input wire logic        mdio_oe,
    input wire phy_events_s ev,
    input wire phy_ctrl_s   ctrl
);
    logic       mdc_ff;
    logic       link_ff;
    logic [4:0] oe_rises_ff;
    logic [2:0] fail_win_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Rises while driving; window after a failure cause
    always_ff @(posedge clk) begin
        mdc_ff <= mdc;
        link_ff <= ev.link_up;
        if (rst || !mdio_oe) begin
            oe_rises_ff <= 5'h00;
        end else if (mdc && !mdc_ff) begin
            oe_rises_ff <= oe_rises_ff + 5'h01;
        end
        if (rst) begin
            fail_win_ff <= 3'h0;
        end else if (ev.an_attempt || (link_ff && !ev.link_up)) begin
            fail_win_ff <= 3'h7;
        end else if (fail_win_ff != 3'h0) begin
            fail_win_ff <= fail_win_ff - 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    out_stands_a: assert property ((($changed(mdio_out) || $changed(mdio_oe)) && !$past(rst))
        |-> ($past(mdc) && !$past(mdc, 2))) else $error("serial output moved without an mdc rise");
    ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_out) else $error("turnaround not driven low");
    read_length_a: assert property ($fell(mdio_oe) |-> oe_rises_ff == 5'h11)
        else $error("read drive window has wrong length");
    dac_awake_a: assert property ((ev.speed != 2'h0 || ev.tx_busy) |=> ctrl.tx_dac_on)
        else $error("dac gated outside idle slow mode");
    carrier_mux_a: assert property ((!$past(rst) && $past(ev.rx_dv) == $past(ev.crs_dv_raw))
        |-> ctrl.crs_dv_pin == $past(ev.rx_dv)) else $error("carrier pin matches neither source");
    strap_load_a: assert property ($fell(rst) |=> ctrl.mac_mode == $past(strap_mode))
        else $error("mode not loaded from strap");
    clk_sel_tie_a: assert property (!$past(rst) |-> ctrl.clk_input == ctrl.mac_mode[0])
        else $error("clock direction differs from mode bit 0");
    dg_hold_a: assert property (($fell(ctrl.speed_downgrade) && !$past(rst) && !$past(rst, 2))
        |-> ($past(soft_rst) || $past(soft_rst, 2) || $past(soft_rst, 3)))
        else $error("downgrade dropped without soft reset");
    dg_cause_a: assert property ($rose(ctrl.speed_downgrade) |-> fail_win_ff != 3'h0)
        else $error("downgrade without a failed attempt");
    quiet_reset_a: assert property ($fell(rst) |-> !mdio_oe && ctrl.tx_dac_on && !ctrl.speed_downgrade)
        else $error("outputs not at reset state");
    cover property ($rose(mdio_oe));
    cover property ($rose(ctrl.speed_downgrade));
    cover property ($fell(ctrl.speed_downgrade));
    cover property (!ctrl.tx_dac_on);
endmodule : phy_mgmt_sva
bind phy_mgmt_status_ext_regs phy_mgmt_sva sva_u (
    .clk(clk), .rst(rst), .soft_rst(soft_rst), .strap_mode(strap_mode),
    .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .ev(ev), .ctrl(ctrl));

// >>> test/phy_mgmt_status_ext_regs_tb.sv
`include "phy_mgmt_params.svh"

module phy_mgmt_status_ext_regs_tb
    import phy_mgmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] PHY = 5'h05;
    typedef struct packed {
        logic [13:0] e;
        logic [15:0] st;
    } row_s;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic        soft_rst   = 1'b0;
    logic [1:0]  strap_mode = 2'h2;
    phy_events_s ev         = '0;
    phy_ctrl_s   ctrl;
    logic        mdc;
    logic        host_oe;
    logic        host_bit;
    logic        mdio_out;
    logic        mdio_oe;
    logic        ta;
    logic [1:0]  m;
    logic [15:0] v;
    wire         mdio_w;
    int          err_count  = 0;
    int          checked    = 0;
    // Levels carry over from row to row; bits 13:8 are one-cycle pulses
    row_s        rows [9]   = '{'{14'h2000, 16'h8000}, '{14'h1000, 16'h1000}, '{14'h0800, 16'h0040},
                                '{14'h0400, 16'h0001}, '{14'h0080, 16'h0400}, '{14'h00c0, 16'h2000},
                                '{14'h00e0, 16'h0002}, '{14'h00e8, 16'h4000}, '{14'h0068, 16'h0800}};
    // Pull-up on the shared line
    assign mdio_w = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);
    always #25 clk = ~clk;
    phy_mgmt_status_ext_regs #(.STABLE_CYCLES(20)) dut_u (
        .clk(clk), .rst(rst), .soft_rst(soft_rst), .phy_addr(PHY), .strap_mode(strap_mode),
        .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .ev(ev), .ctrl(ctrl));
    mdio_host_model host_u (.clk(clk), .mdio(mdio_w), .mdc(mdc), .drv_oe(host_oe), .drv_bit(host_bit));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge clk) #1;
    endtask : step
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic mwr(input logic [4:0] r, input logic [15:0] d);
        logic [15:0] rd;
        logic        t;
        host_u.frame(`MDIO_OP_WRITE, PHY, r, d, rd, t);
    endtask : mwr
    task automatic rdchk(input logic [4:0] r, input logic [15:0] exp);
        logic [15:0] rd;
        logic        t;
        host_u.frame(`MDIO_OP_READ, PHY, r, 16'h0000, rd, t);
        chk("turnaround", 16'(t), 16'h0001);
        chk($sformatf("reg %h", r), rd, exp);
    endtask : rdchk
    task automatic xwr(input logic [15:0] idx, input logic [15:0] d);
        mwr(`REG_EXT_INDEX, idx);
        mwr(`REG_EXTENDED_WINDOW_DATA, d);
    endtask : xwr
    task automatic xrd(input logic [15:0] idx, input logic [15:0] exp);
        mwr(`REG_EXT_INDEX, idx);
        rdchk(`REG_EXTENDED_WINDOW_DATA, exp);
    endtask : xrd
    task automatic apply(input logic [13:0] e);
        step();
        ev = e;
        step();
        ev = ev & 14'h00ff;
    endtask : apply
    task automatic att(input int n);
        repeat (n) begin
            apply(ev | 14'h0100);
            step();
        end
    endtask : att
    task automatic flap();
        step();
        ev.link_up = 1'b1;
        repeat (5) step();
        ev.link_up = 1'b0;
        repeat (5) step();
    endtask : flap
    task automatic sr();
        step();
        soft_rst = 1'b1;
        step();
        soft_rst = 1'b0;
        repeat (3) step();
    endtask : sr
    task automatic dgchk(input logic exp);
        repeat (6) step();
        chk("downgrade", 16'(ctrl.speed_downgrade), 16'(exp));
    endtask : dgchk
    task automatic report_and_stop();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    // Run bound
    initial begin
        repeat (95000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) step();
        chk("strap mode", 16'(ctrl.mac_mode), 16'h0002);
        foreach (rows[i]) begin
            apply(rows[i].e);
            rdchk(`REG_INT_STATUS, rows[i].st);
            rdchk(`REG_INT_STATUS, 16'h0000);
        end
        mwr(`REG_INT_ENABLE, 16'h0001);
        apply(ev | 14'h0800);
        repeat (3) step();
        chk("irq masked", 16'(ctrl.irq), 16'h0000);
        apply(ev | 14'h0400);
        repeat (3) step();
        chk("irq on", 16'(ctrl.irq), 16'h0001);
        rdchk(`REG_INT_STATUS, 16'h0041);
        chk("irq cleared", 16'(ctrl.irq), 16'h0000);
        ev.rx_dv = 1'b1;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            v = {4'h0, m[1], 5'h00, m[0], m[1], 1'b0, m[0], m};
            xwr(`EXT_COMBO, v);
            rdchk(`REG_EXTENDED_WINDOW_DATA, v);
            chk("combo ctrl", 16'({ctrl.mac_mode, ctrl.clk_input, ctrl.jumbo_accept, ctrl.crs_dv_pin,
                ctrl.wol_enable, ctrl.remote_loopback}), 16'({m, m[0], m[0], m[1], m[0], m[1]}));
        end
        xwr(`EXT_SLOW_POWER, 16'hce02);
        ev.speed = 2'h0;
        repeat (3) step();
        chk("dac idle", 16'(ctrl.tx_dac_on), 16'h0000);
        ev.tx_busy = 1'b1;
        repeat (3) step();
        chk("dac busy", 16'(ctrl.tx_dac_on), 16'h0001);
        ev.tx_busy = 1'b0;
        ev.speed = 2'h1;
        repeat (3) step();
        chk("dac fast", 16'(ctrl.tx_dac_on), 16'h0001);
        mwr(`REG_RX_ERRORS, 16'h0000);
        // Errors arrive only after the read value was captured
        fork
            host_u.frame(`MDIO_OP_READ, PHY, `REG_RX_ERRORS, 16'h0000, v, ta);
            begin
                for (int n = 0; n < 2000 && !mdio_oe; n++) step();
                ev.rx_er = 1'b1;
                repeat (100) step();
                ev.rx_er = 1'b0;
            end
        join
        chk("latched read", v, 16'h0000);
        rdchk(`REG_RX_ERRORS, 16'h0064);
        ev.rx_er = 1'b1;
        repeat (65540) step();
        ev.rx_er = 1'b0;
        rdchk(`REG_RX_ERRORS, 16'hffff);
        sr();
        att(4);
        dgchk(1'b0);
        att(1);
        dgchk(1'b1);
        sr();
        mwr(`REG_SPEED_CFG, 16'h0820);
        att(2);
        dgchk(1'b0);
        att(3);
        dgchk(1'b1);
        sr();
        flap();
        flap();
        dgchk(1'b1);
        mwr(`REG_SPEED_CFG, 16'h0822);
        sr();
        flap();
        flap();
        dgchk(1'b0);
        mwr(`REG_SPEED_CFG, 16'h0800);
        att(2);
        dgchk(1'b1);
        sr();
        att(2);
        dgchk(1'b0);
        host_u.slow = 3;
        host_u.frame(`MDIO_OP_READ, PHY + 5'h01, `REG_INT_STATUS, 16'h0000, v, ta);
        chk("foreign address", v, 16'hffff);
        mwr(5'h02, 16'hffff);
        rdchk(5'h02, 16'h0000);
        xrd(16'h1234, 16'h0000);
        rdchk(`REG_EXT_INDEX, 16'h1234);
        host_u.slow = 0;
        strap_mode = 2'h1;
        mwr(`REG_SPEED_CFG, 16'h0000);
        rdchk(`REG_INT_STATUS, 16'h0000);
        rst = 1'b1;
        repeat (8) step();
        rst = 1'b0;
        rdchk(`REG_INT_STATUS, 16'h0000);
        rdchk(`REG_SPEED_CFG, 16'h082c);
        rdchk(`REG_RX_ERRORS, 16'h0000);
        rdchk(`REG_EXT_INDEX, 16'h0000);
        xrd(`EXT_SLOW_POWER, 16'hca02);
        xrd(`EXT_COMBO, 16'h0001);
        chk("strap mode", 16'(ctrl.mac_mode), 16'h0001);
        report_and_stop();
    end
endmodule : phy_mgmt_status_ext_regs_tb
